// ### sbp_pins.sv
`timescale 1ns/100ps
module sbp_pins (
  input  wire logic       clk,
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe,
  input  wire logic [5:0] pin_pullup,
  input  wire logic [5:0] ext_val,
  input  wire logic [5:0] ext_en,
  output logic      [5:0] pin_in
);
  logic [5:0] flt = 6'h00;

  // Undriven pins wander
  always @(posedge clk)
    flt <= ~flt;

  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pin_pullup | flt));
endmodule

// ### sbp_pkg.sv
package sbp_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] SBP_OFS_PORT    = 8'h00;
  localparam logic [7:0] SBP_OFS_DIR     = 8'h04;
  localparam logic [7:0] SBP_OFS_ANSL    = 8'h08;
  localparam logic [7:0] SBP_OFS_ANSH    = 8'h0c;
  localparam logic [7:0] SBP_OFS_PULLUP  = 8'h10;
  localparam logic [7:0] SBP_OFS_IOC     = 8'h14;
  localparam logic [7:0] SBP_OFS_CTRL    = 8'h18;
  localparam logic [7:0] SBP_OFS_CONFIG  = 8'h1c;
  localparam logic [7:0] SBP_OFS_PORTSET = 8'h20;
  localparam logic [7:0] SBP_OFS_PORTCLR = 8'h24;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SBP_CTRL_GPD_BIT   = 0;
  localparam int SBP_CTRL_FLAG_BIT  = 1;
  localparam int SBP_CFG_MASTER_CLEAR_ENABLE_BIT  = 0;
  localparam int SBP_CFG_XTAL_BIT   = 1;
  localparam int SBP_PIN_THREE      = 3;

  // ----------------------------------------
  // Reset values and fixed masks
  // ----------------------------------------
  localparam logic [5:0] SBP_RST_DIR    = 6'h3f;
  localparam logic [7:0] SBP_RST_ANSL   = 8'hff;
  localparam logic [3:0] SBP_RST_ANSH   = 4'hf;
  localparam logic [5:0] SBP_RST_PULLUP = 6'h37;
  localparam logic [5:0] SBP_RST_IOC    = 6'h00;
  localparam logic [5:0] SBP_RST_LATCH  = 6'h00;
  localparam logic       SBP_RST_GPD    = 1'b1;
  localparam logic [5:0] SBP_MASK_PIN3  = 6'h08;
  localparam logic [5:0] SBP_MASK_OSC   = 6'h30;
  localparam logic [5:0] SBP_MASK_PU    = 6'h37;

endpackage

// ### sbp_port.sv
`timescale 1ns/100ps
// How it works
// - Six pins, each with output latch and input path; all but pin three also have a driver.
// - Direction one turns driver off; zero drives the latch onto the pin.
// - Pin three is input only; its direction bit reads one, writes ignored.
// - Port read returns sampled pin levels; port write loads the output latch.
// - Port bit-modify writes read pins, modify bits, store result into latch.
// - With master clear enabled, pin three data reads zero.
// - Analog-selected pins read zero, also in read-modify-write read phase.
// - Analog select leaves output drive alone; latch still driven when output.
// - Four low analog select bits; one means analog, zero digital.
// - Analog select disables digital input, pull-up and change detection.
// - All pins but three have a weak pull-up with its own enable bit.
// - Pull-up forced off while the pin is an output.
// - Power-on reset disables pull-ups through the global disable bit.
// - Pin three pull-up follows master clear enable, no software control.
// - Per-pin change enables, cleared by power-on reset.
// - Enabled pins compared with last-read value; mismatches ORed into flag.
// - Pending change flag can wake the device from sleep.
// - Mismatch keeps setting flag; software reloads latch, then clears flag.
// - Last-read latch survives warm resets; flag sets again on mismatch.
// - Change coinciding with a port read sample still sets the flag.
// - In crystal oscillator mode direction bits five and four read one.
// - Individual pull-up acts only when global disable bit permits.
// - Change enable bit one enables detection, zero disables; reset zero.
module sbp_port
  import sbp_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        WARM_RESET,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [5:0]  PIN_IN,
  output logic      [5:0]  PIN_OUT,
  output logic      [5:0]  PIN_OE,
  output logic      [5:0]  PIN_PULLUP,
  output logic             WAKE
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [5:0]  sync1;
    logic [5:0]  sync2;
    logic [5:0]  sync3;
    logic [5:0]  lvl;
    logic [5:0]  lat;
    logic [5:0]  dir;
    logic [7:0]  ansl;
    logic [3:0]  ansh;
    logic [5:0]  wpu;
    logic [5:0]  ioc;
    logic [5:0]  last;
    logic        flag;
    logic        gpd;
    logic        master_clear_enable;
    logic        xtal;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [5:0]  pin_out;
    logic [5:0]  pin_oe;
    logic [5:0]  pin_pu;
    logic        wake;
  } sbp_state_t;

  localparam sbp_state_t SBP_RST_STATE = '{
    sync1:   6'h00,
    sync2:   6'h00,
    sync3:   6'h00,
    lvl:     6'h00,
    lat:     SBP_RST_LATCH,
    dir:     SBP_RST_DIR,
    ansl:    SBP_RST_ANSL,
    ansh:    SBP_RST_ANSH,
    wpu:     SBP_RST_PULLUP,
    ioc:     SBP_RST_IOC,
    last:    6'h00,
    flag:    1'b0,
    gpd:     SBP_RST_GPD,
    master_clear_enable:   1'b0,
    xtal:    1'b0,
    prdata:  32'h0,
    pready:  1'b0,
    pslverr: 1'b0,
    pin_out: 6'h00,
    pin_oe:  6'h00,
    pin_pu:  6'h00,
    wake:    1'b0
  };

  sbp_state_t q;
  sbp_state_t next_q;

  logic [5:0]  an_mask;
  logic [5:0]  dig_rd;
  logic [5:0]  dir_rd;
  logic [5:0]  ioc_rd;
  logic [5:0]  wpu_rd;
  logic [5:0]  mism;
  logic        setup;
  logic        access;
  logic        wr;
  logic        rd;
  logic        mapped;
  logic [31:0] rdata;

  // ----------------------------------------
  // Derived views
  // ----------------------------------------
  always_comb
  begin
    // Analog channels sit on pins 0, 1, 2 and 4
    an_mask = {1'b0, q.ansl[3], 1'b0, q.ansl[2:0]};
    dig_rd  = q.lvl & ~an_mask;
    if (q.master_clear_enable)
    begin
      dig_rd = dig_rd & ~SBP_MASK_PIN3;
    end
    dir_rd = q.dir | SBP_MASK_PIN3;
    ioc_rd = q.ioc;
    wpu_rd = q.wpu & SBP_MASK_PU;
    if (q.xtal)
    begin
      dir_rd = dir_rd | SBP_MASK_OSC;
      ioc_rd = ioc_rd | SBP_MASK_OSC;
      wpu_rd = wpu_rd | SBP_MASK_OSC;
    end
    // Change detection sees the same zeroed view as software
    mism   = (dig_rd ^ q.last) & q.ioc & ~an_mask;
    setup  = PSEL && !PENABLE && !q.pready;
    access = PSEL && PENABLE && q.pready;
    wr     = access && PWRITE;
    rd     = access && !PWRITE;
  end

  // ----------------------------------------
  // Read mux and address decode
  // ----------------------------------------
  always_comb
  begin
    rdata  = 32'h0;
    mapped = 1'b1;
    case (PADDR)
      SBP_OFS_PORT:    rdata = {26'h0, dig_rd};
      SBP_OFS_DIR:     rdata = {26'h0, dir_rd};
      SBP_OFS_ANSL:    rdata = {24'h0, q.ansl};
      SBP_OFS_ANSH:    rdata = {28'h0, q.ansh};
      SBP_OFS_PULLUP:  rdata = {26'h0, wpu_rd};
      SBP_OFS_IOC:     rdata = {26'h0, ioc_rd};
      SBP_OFS_CTRL:    rdata = {30'h0, q.flag, q.gpd};
      SBP_OFS_CONFIG:  rdata = {30'h0, q.xtal, q.master_clear_enable};
      SBP_OFS_PORTSET: rdata = {26'h0, q.lat};
      SBP_OFS_PORTCLR: rdata = {26'h0, q.lat};
      default:         mapped = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_q = q;

    // Three-stage pin sampling; level moves when stages two and three agree
    next_q.sync1 = PIN_IN;
    next_q.sync2 = q.sync1;
    next_q.sync3 = q.sync2;
    for (int i = 0; i < 6; i++)
    begin
      if (q.sync2[i] == q.sync3[i])
      begin
        next_q.lvl[i] = q.sync3[i];
      end
    end

    // Bus slave: no wait states, answer registered at setup
    next_q.pready  = setup;
    next_q.pslverr = setup && !mapped;
    if (setup)
    begin
      next_q.prdata = PWRITE ? 32'h0 : rdata;
    end

    if (wr)
    begin
      case (PADDR)
        SBP_OFS_PORT:    next_q.lat  = PWDATA[5:0];
        SBP_OFS_PORTSET: next_q.lat  = dig_rd | PWDATA[5:0];
        SBP_OFS_PORTCLR: next_q.lat  = dig_rd & ~PWDATA[5:0];
        SBP_OFS_DIR:     next_q.dir  = PWDATA[5:0] | SBP_MASK_PIN3;
        SBP_OFS_ANSL:    next_q.ansl = PWDATA[7:0];
        SBP_OFS_ANSH:    next_q.ansh = PWDATA[3:0];
        SBP_OFS_PULLUP:  next_q.wpu  = PWDATA[5:0] & SBP_MASK_PU;
        SBP_OFS_IOC:     next_q.ioc  = PWDATA[5:0];
        SBP_OFS_CTRL:    next_q.gpd  = PWDATA[SBP_CTRL_GPD_BIT];
        SBP_OFS_CONFIG:
        begin
          next_q.master_clear_enable = PWDATA[SBP_CFG_MASTER_CLEAR_ENABLE_BIT];
          next_q.xtal  = PWDATA[SBP_CFG_XTAL_BIT];
        end
        default:
        begin
        end
      endcase
    end

    // Any port access reloads the compare latch with what was read
    if (access && (PADDR == SBP_OFS_PORT || PADDR == SBP_OFS_PORTSET ||
                   PADDR == SBP_OFS_PORTCLR))
    begin
      // Value returned is the one sampled at setup
      next_q.last = rd ? q.prdata[5:0] : dig_rd;
    end

    // Flag: cleared by writing zero, mismatch wins
    if (wr && PADDR == SBP_OFS_CTRL && !PWDATA[SBP_CTRL_FLAG_BIT])
    begin
      next_q.flag = 1'b0;
    end
    if (|mism)
    begin
      next_q.flag = 1'b1;
    end

    // Warm reset: last-read latch and output latch untouched
    if (WARM_RESET)
    begin
      next_q.dir     = SBP_RST_DIR;
      next_q.ansl    = SBP_RST_ANSL;
      next_q.ansh    = SBP_RST_ANSH;
      next_q.wpu     = SBP_RST_PULLUP;
      next_q.ioc     = SBP_RST_IOC;
      next_q.gpd     = SBP_RST_GPD;
      next_q.flag    = |mism;
      next_q.prdata  = 32'h0;
      next_q.pready  = 1'b0;
      next_q.pslverr = 1'b0;
    end

    // Pin drivers, from current settings
    next_q.pin_out = q.lat;
    next_q.pin_oe  = ~dir_rd & ~SBP_MASK_PIN3;
    for (int i = 0; i < 6; i++)
    begin
      next_q.pin_pu[i] = q.wpu[i] & ~q.gpd & dir_rd[i] & ~an_mask[i];
    end
    next_q.pin_pu[SBP_PIN_THREE] = q.master_clear_enable;
    next_q.wake = q.flag;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      q <= SBP_RST_STATE;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign PRDATA     = q.prdata;
  assign PREADY     = q.pready;
  assign PSLVERR    = q.pslverr;
  assign PIN_OUT    = q.pin_out;
  assign PIN_OE     = q.pin_oe;
  assign PIN_PULLUP = q.pin_pu;
  assign WAKE       = q.wake;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  a_pin3_nodrive: assert property (!PIN_OE[SBP_PIN_THREE])
    else $error("pin three driven");
  a_dir3_reads: assert property (PREADY && PSEL && !PWRITE && PADDR == SBP_OFS_DIR
    |-> PRDATA[SBP_PIN_THREE])
    else $error("direction bit three read zero");
  a_analog_zero: assert property (PREADY && PSEL && !PWRITE && PADDR == SBP_OFS_PORT
    && !WARM_RESET |-> (PRDATA[5:0] & an_mask) == 6'h00)
    else $error("analog pin read nonzero");
  a_pull_outoff: assert property ((PIN_OE & PIN_PULLUP) == 6'h00)
    else $error("pull-up on driven pin");
  a_flag_sets: assert property ((|mism) && !WARM_RESET |=> q.flag ##1 WAKE)
    else $error("mismatch did not raise flag and wake");
  a_flag_holds: assert property (q.flag && !WARM_RESET && !(wr && PADDR == SBP_OFS_CTRL)
    |=> q.flag)
    else $error("flag dropped without clear");
  a_last_load: assert property (rd && PADDR == SBP_OFS_PORT && !WARM_RESET
    |=> q.last == $past(PRDATA[5:0]))
    else $error("compare latch not loaded by read");
  a_last_warm: assert property (WARM_RESET && !access |=> q.last == $past(q.last))
    else $error("compare latch lost on warm reset");
  a_drive_latch: assert property (wr && PADDR == SBP_OFS_PORT && !WARM_RESET
    |=> ##1 PIN_OUT == $past(PWDATA[5:0], 2))
    else $error("port write did not reach pins");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");

  // ----------------------------------------
  // Pin driver, direction, port read and pull-up checks
  // ----------------------------------------
  a_oe_follow: assert property (PIN_OE == ($past(~dir_rd) & ~SBP_MASK_PIN3))
    else $error("driver enable does not follow direction");
  a_dir3_kept: assert property (wr && PADDR == SBP_OFS_DIR |=> q.dir[SBP_PIN_THREE])
    else $error("direction bit three written");
  a_master_clear_pin_zero: assert property (PREADY && PSEL && !PWRITE && PADDR == SBP_OFS_PORT
    && $past(q.master_clear_enable) |-> !PRDATA[SBP_PIN_THREE])
    else $error("pin three read nonzero with master clear");
  a_pu3_master_clear_pin: assert property (PIN_PULLUP[SBP_PIN_THREE] == $past(q.master_clear_enable))
    else $error("pin three pull-up not tied to master clear");
  a_pu_global: assert property (q.gpd |=> (PIN_PULLUP & SBP_MASK_PU) == 6'h00)
    else $error("pull-up on while globally disabled");
  a_pu_analog: assert property ((PIN_PULLUP & $past(an_mask)) == 6'h00)
    else $error("pull-up on analog pin");
  a_osc_dir: assert property (PREADY && PSEL && !PWRITE && PADDR == SBP_OFS_DIR
    && $past(q.xtal) |-> PRDATA[5:4] == 2'b11)
    else $error("oscillator direction bits read zero");
  a_osc_nodrive: assert property (q.xtal |=> PIN_OE[5:4] == 2'b00)
    else $error("oscillator pins driven");

  // ----------------------------------------
  // Change detection checks
  // ----------------------------------------
  a_warm_config: assert property (WARM_RESET |=> q.ioc == SBP_RST_IOC && q.gpd)
    else $error("warm reset left change enables set");
  a_wake_copy: assert property (WAKE == $past(q.flag))
    else $error("wake does not follow flag");
  a_last_hold: assert property (!access |=> $stable(q.last))
    else $error("compare latch moved without port access");
  a_flag_clear: assert property (wr && PADDR == SBP_OFS_CTRL && !PWDATA[SBP_CTRL_FLAG_BIT]
    && !(|mism) |=> !q.flag)
    else $error("flag not cleared by writing zero");

  c_port_read: cover property (rd && PADDR == SBP_OFS_PORT);
  c_flag_rise: cover property (!q.flag ##1 q.flag);
  c_rmw_set:   cover property (wr && PADDR == SBP_OFS_PORTSET && (an_mask & PWDATA[5:0]) != 0);
  c_clear_race: cover property (wr && PADDR == SBP_OFS_CTRL && (|mism));
  c_warm_mism: cover property (WARM_RESET && (|mism));

endmodule

// ### tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import sbp_pkg::*;
  logic        CLK = 0, RESETN = 0, WARM_RESET = 0;
  logic        PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, r;
  logic        PREADY, PSLVERR, WAKE, err;
  logic [5:0]  PIN_IN, PIN_OUT, PIN_OE, PIN_PULLUP;
  logic [5:0]  ext_val = 6'h00;
  int          miscompares = 0, tests_run = 0;

  always #25 CLK = ~CLK;

  sbp_port dut (.CLK(CLK), .RESETN(RESETN), .WARM_RESET(WARM_RESET), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PIN_IN(PIN_IN),
    .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PIN_PULLUP(PIN_PULLUP), .WAKE(WAKE));

  sbp_pins far (.clk(CLK), .pin_out(PIN_OUT), .pin_oe(PIN_OE),
    .pin_pullup(PIN_PULLUP), .ext_val(ext_val), .ext_en(6'h3f), .pin_in(PIN_IN));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    // Sampled at the rising edge, before the design's flops update
    do
    begin
      @(posedge CLK);
      n++;
    end
    while (PREADY !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 0, 1);
    r = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    // Idle cycle so the next call never re-drives in this time step
    @(posedge CLK);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, r, exp);
  endtask

  task automatic settle();
    repeat (6) @(posedge CLK);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rdchk("dir", SBP_OFS_DIR, 32'h3f);
    rdchk("ansl", SBP_OFS_ANSL, 32'hff);
    rdchk("pullup", SBP_OFS_PULLUP, 32'h37);
    rdchk("ioc", SBP_OFS_IOC, 32'h00);
    rdchk("ctrl", SBP_OFS_CTRL, 32'h01);
    chk("oe", PIN_OE, 6'h00);
    chk("pu", PIN_PULLUP, 6'h00);
    rdchk("unmapped", 8'h30, 32'h0);
    chk("slverr", err, 1'b1);
    $display("reset test done");
  endtask

  task automatic t_drive();
    wr(SBP_OFS_ANSL, 32'h0);
    wr(SBP_OFS_DIR, 32'h0);
    rdchk("dir3", SBP_OFS_DIR, 32'h08);
    wr(SBP_OFS_PORT, 32'h22);
    settle();
    chk("oe", PIN_OE, 6'h37);
    chk("out", PIN_OUT & 6'h37, 6'h22);
    rdchk("port", SBP_OFS_PORT, 32'h22);
    wr(SBP_OFS_CONFIG, 32'h2);
    rdchk("dirx", SBP_OFS_DIR, 32'h38);
    wr(SBP_OFS_CONFIG, 32'h0);
    $display("drive test done");
  endtask

  task automatic t_analog();
    ext_val <= 6'h3f;
    wr(SBP_OFS_DIR, 32'h3f);
    settle();
    rdchk("port", SBP_OFS_PORT, 32'h3f);
    wr(SBP_OFS_ANSL, 32'h05);
    rdchk("port_an", SBP_OFS_PORT, 32'h3a);
    wr(SBP_OFS_PORTSET, 32'h0);
    wr(SBP_OFS_DIR, 32'h0);
    settle();
    chk("out", PIN_OUT & 6'h37, 6'h32);
    chk("oe", PIN_OE, 6'h37);
    wr(SBP_OFS_CONFIG, 32'h1);
    settle();
    rdchk("port_mc", SBP_OFS_PORT, 32'h32);
    chk("pu3", PIN_PULLUP, 6'h08);
    wr(SBP_OFS_CONFIG, 32'h0);
    $display("analog test done");
  endtask

  task automatic t_pullup();
    wr(SBP_OFS_PULLUP, 32'h3f);
    rdchk("pullup", SBP_OFS_PULLUP, 32'h37);
    wr(SBP_OFS_ANSL, 32'h02);
    wr(SBP_OFS_DIR, 32'h3e);
    wr(SBP_OFS_CTRL, 32'h0);
    settle();
    chk("pu", PIN_PULLUP, 6'h34);
    wr(SBP_OFS_CTRL, 32'h1);
    settle();
    chk("pu_off", PIN_PULLUP, 6'h00);
    $display("pullup test done");
  endtask

  task automatic t_change();
    wr(SBP_OFS_ANSL, 32'h0);
    wr(SBP_OFS_DIR, 32'h3f);
    ext_val <= 6'h00;
    settle();
    rdchk("noioc", SBP_OFS_CTRL, 32'h01);
    wr(SBP_OFS_IOC, 32'h3f);
    rdchk("port", SBP_OFS_PORT, 32'h00);
    wr(SBP_OFS_CTRL, 32'h1);
    ext_val <= 6'h10;
    settle();
    rdchk("flag", SBP_OFS_CTRL, 32'h03);
    chk("wake", WAKE, 1'b1);
    wr(SBP_OFS_CTRL, 32'h1);
    rdchk("flag_kept", SBP_OFS_CTRL, 32'h03);
    rdchk("port", SBP_OFS_PORT, 32'h10);
    wr(SBP_OFS_CTRL, 32'h1);
    rdchk("flag_clr", SBP_OFS_CTRL, 32'h01);
    WARM_RESET <= 1;
    @(posedge CLK);
    WARM_RESET <= 0;
    wr(SBP_OFS_IOC, 32'h3f);
    settle();
    rdchk("warm", SBP_OFS_CTRL, 32'h01);
    chk("wake0", WAKE, 1'b0);
    $display("change test done");
  endtask

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge CLK);
    miscompares++;
    tally_and_finish();
  end

  initial
  begin
    repeat (16) @(posedge CLK);
    RESETN <= 1;
    @(posedge CLK);
    t_reset();
    t_drive();
    t_analog();
    t_pullup();
    t_change();
    tally_and_finish();
  end
endmodule
